// *** src/smp_pkg.sv ***
package smp_pkg;

   // register map, byte addresses on a 32-bit bus
   localparam int           SMP_AW          = 8;
   localparam logic [7:0]   SMP_ADDR_CTRL   = 8'h00;
   localparam logic [7:0]   SMP_ADDR_DLY1   = 8'h04;
   localparam logic [7:0]   SMP_ADDR_DLY2   = 8'h08;
   localparam logic [7:0]   SMP_ADDR_STATUS = 8'h0c;
   localparam logic [7:0]   SMP_ADDR_ERR    = 8'h10;

   localparam logic [1:0]   SMP_RESP_OKAY   = 2'h0;
   localparam logic [1:0]   SMP_RESP_SLVERR = 2'h2;

   // control register fields
   localparam int           SMP_CTRL_RUN    = 0;
   localparam int           SMP_CTRL_SHEAR1 = 1;
   localparam int           SMP_CTRL_SHEAR2 = 2;

   // overspeed switch-off delay in ms
   localparam int           SMP_DLY_W       = 12;
   localparam logic [11:0]  SMP_DLY_MAX_MS  = 12'h9c4;
   localparam logic [11:0]  SMP_DLY_RST     = 12'h000;

   // status register fields
   localparam int           SMP_ST_AXIS2    = 4;
   localparam int           SMP_ST_EXT      = 8;
   localparam int           SMP_ST_INT      = 9;
   localparam int           SMP_ST_DIRV     = 10;
   localparam int           SMP_ST_READY    = 11;
   localparam int           SMP_ST_CNT      = 12;

   // error stack read word
   localparam int           SMP_ERR_VALID   = 8;
   localparam int           SMP_ERR_OVF     = 9;
   localparam int           SMP_STK_DEPTH   = 8;
   localparam int           SMP_ENTRY_W     = 5;

   // timing
   localparam int           SMP_CLK_NS      = 10;
   localparam int           SMP_MS_NS       = 1000000;
   localparam int           SMP_MS_CYCLES   = SMP_MS_NS / SMP_CLK_NS;
   localparam logic [9:0]   SMP_DIR_HOLD_MS = 10'h1f4;
   localparam int           SMP_BLINK_SLOW  = 9;
   localparam int           SMP_BLINK_FAST  = 7;

   typedef struct packed {
      logic track_a;
      logic track_b;
      logic prox_a;
      logic prox_b;
      logic ovs_exceed;
      logic enc_connected;
      logic enc_short;
      logic direction;
   } smp_axis_in_t;

   // code = {broken shear pin, track a, track b, prox}
   typedef struct packed {
      logic       standstill;
      logic       ovs_ok;
      logic       diag9;
      logic       diag10;
      logic       log_req;
      logic [3:0] code;
   } smp_axis_out_t;

endpackage

// *** src/smp_axis.sv ***
`timescale 1ns/1ns
`default_nettype none
module smp_axis (
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 run_i,
   input  wire logic                 shear_en_i,
   input  wire logic [11:0]          delay_ms_i,
   input  wire logic                 ms_tick_i,
   input  wire smp_pkg::smp_axis_in_t in_i,
   output smp_pkg::smp_axis_out_t    out_o
);

   typedef enum logic [2:0] {
      SMP_OVS_OK   = 3'b001,
      SMP_OVS_WAIT = 3'b010,
      SMP_OVS_TRIP = 3'b100
   } smp_ovs_t;

   typedef struct packed {
      smp_ovs_t               ovs;
      logic [11:0]            dcnt;
      logic                   err_q;
      smp_pkg::smp_axis_out_t out;
   } smp_axis_state_t;

   smp_axis_state_t s;
   smp_axis_state_t next_s;

   always_comb begin
      logic prox;
      logic ok_rot;
      logic ss;
      logic ok;
      logic d9;
      logic d10;
      logic err;
      prox   = 1'b0;
      ok_rot = 1'b1;
      ss     = 1'b1;
      ok     = 1'b1;
      d9     = 1'b0;
      d10    = 1'b0;
      err    = 1'b0;
      next_s = s;
      prox   = in_i.prox_a | in_i.prox_b;
      // overspeed-ok falls only after the configured delay
      unique case (s.ovs)
         SMP_OVS_OK: begin
            next_s.dcnt = 12'h000;
            if (in_i.ovs_exceed) begin
               next_s.ovs = (delay_ms_i == 12'h000) ? SMP_OVS_TRIP : SMP_OVS_WAIT;
            end
         end
         SMP_OVS_WAIT: begin
            if (!in_i.ovs_exceed) begin
               next_s.ovs = SMP_OVS_OK;
            end else if (ms_tick_i) begin
               next_s.dcnt = s.dcnt + 12'h001;
               // ticks are free running, so one extra tick keeps the wait from running short
               if (s.dcnt >= delay_ms_i) begin
                  next_s.ovs = SMP_OVS_TRIP;
               end
            end
         end
         SMP_OVS_TRIP: begin
            if (!in_i.ovs_exceed) begin
               next_s.ovs = SMP_OVS_OK;
            end
         end
         default: next_s.ovs = SMP_OVS_OK;
      endcase
      if (!run_i) begin
         next_s.ovs = SMP_OVS_OK;
      end
      ok_rot = (next_s.ovs != SMP_OVS_TRIP);
      unique case ({in_i.track_a, in_i.track_b, prox})
         3'b000: ;
         3'b001: begin
            d9 = 1'b1;
            if (shear_en_i) begin
               ss  = 1'b0;
               ok  = 1'b0;
               err = 1'b1;
            end
         end
         3'b010, 3'b100: ;
         3'b011, 3'b101: begin
            ss  = 1'b0;
            ok  = ok_rot;
            d10 = 1'b1;
            err = 1'b1;
         end
         3'b110: begin
            ss  = 1'b0;
            ok  = ok_rot;
            d9  = 1'b1;
            err = 1'b1;
         end
         3'b111: begin
            ss = 1'b0;
            ok = ok_rot;
         end
      endcase
      // not running or faulted: safe condition, nothing logged
      if (!run_i) begin
         ss  = 1'b0;
         ok  = 1'b0;
         d9  = 1'b0;
         d10 = 1'b0;
         err = 1'b0;
      end
      next_s.err_q          = err;
      next_s.out.standstill = ss;
      next_s.out.ovs_ok     = ok;
      next_s.out.diag9      = d9;
      next_s.out.diag10     = d10;
      next_s.out.log_req    = err & ~s.err_q;
      next_s.out.code       = {shear_en_i & prox & ~in_i.track_a & ~in_i.track_b,
                               in_i.track_a, in_i.track_b, prox};
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s     <= '0;
         s.ovs <= SMP_OVS_OK;
      end else begin
         s <= next_s;
      end
   end

   assign out_o = s.out;

endmodule
`default_nettype wire

// *** src/smp_monitor.sv ***
// Operation
// - ready indicator is steadily lit while operational, never blinking.
// - encoder input fault: safe condition, fault lit, that connection indicator blinks.
// - internal fault: safe condition and fault indicator blinks.
// - encoder or wiring fault shows as brief flash on the axis indicator.
// - axis indicator: slow blink normal, steady standstill, fast blink overspeed.
// - encoder connection indicator steady while encoder is correctly connected.
// - each proximity input indicator lit while that input is energised.
// - an input flag is 1 with pulses detected, 0 without.
// - no pulses anywhere: standstill, overspeed-ok, no diagnostics, no log.
// - proximity only, shear option off: standstill kept, bit 9 only.
// - proximity only, shear option on: outputs drop, bit 9, logged.
// - one track only, no proximity: standstill kept, nothing set or logged.
// - proximity plus one track: standstill drops, bit 10, logged.
// - both tracks, no proximity: standstill drops, bit 9, logged.
// - all inputs pulsing: standstill drops, no diagnostics, no log.
// - overspeed-ok is 1 unless the configured threshold is exceeded.
// - direction is marked unreliable for 500 ms after a fault.
// - overspeed-ok falls only after the configured 0 to 2500 ms delay.
//
// The register addresses and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module smp_monitor #(
   parameter int MS_CYCLES = smp_pkg::SMP_MS_CYCLES
) (
   input  wire logic                  clk_i,
   input  wire logic                  rst_i,
   input  wire logic [7:0]            s_axi_awaddr_i,
   input  wire logic                  s_axi_awvalid_i,
   output logic                       s_axi_awready_o,
   input  wire logic [31:0]           s_axi_wdata_i,
   input  wire logic [3:0]            s_axi_wstrb_i,
   input  wire logic                  s_axi_wvalid_i,
   output logic                       s_axi_wready_o,
   output logic [1:0]                 s_axi_bresp_o,
   output logic                       s_axi_bvalid_o,
   input  wire logic                  s_axi_bready_i,
   input  wire logic [7:0]            s_axi_araddr_i,
   input  wire logic                  s_axi_arvalid_i,
   output logic                       s_axi_arready_o,
   output logic [31:0]                s_axi_rdata_o,
   output logic [1:0]                 s_axi_rresp_o,
   output logic                       s_axi_rvalid_o,
   input  wire logic                  s_axi_rready_i,
   input  wire smp_pkg::smp_axis_in_t axis1_i,
   input  wire smp_pkg::smp_axis_in_t axis2_i,
   input  wire logic                  internal_fault_i,
   output logic [1:0]                 standstill_o,
   output logic [1:0]                 ovs_ok_o,
   output logic [1:0]                 diag9_o,
   output logic [1:0]                 diag10_o,
   output logic [1:0]                 direction_o,
   output logic                       direction_valid_o,
   output logic                       ready_led_o,
   output logic                       fault_led_o,
   output logic                       axis1_state_indicator_o,
   output logic                       axis2_state_indicator_o,
   output logic                       axis1_encoder_port_led_o,
   output logic                       axis2_encoder_port_led_o,
   output logic                       axis1_prox_input_a_led_o,
   output logic                       axis1_prox_input_b_led_o,
   output logic                       axis2_prox_input_a_led_o,
   output logic                       axis2_prox_input_b_led_o
);

   typedef struct packed {
      logic                                             aw_full;
      logic [7:0]                                       aw_addr;
      logic                                             w_full;
      logic [31:0]                                      w_data;
      logic [3:0]                                       w_strb;
      logic                                             bvalid;
      logic [1:0]                                       bresp;
      logic                                             rvalid;
      logic [31:0]                                      rdata;
      logic [1:0]                                       rresp;
      logic                                             run;
      logic [1:0]                                       shear;
      logic [11:0]                                      dly1;
      logic [11:0]                                      dly2;
      logic [31:0]                                      ms_cnt;
      logic                                             ms_tick;
      logic [9:0]                                       blink;
      logic [1:0]                                       pend;
      logic [smp_pkg::SMP_STK_DEPTH-1:0][4:0]           stk;
      logic [3:0]                                       cnt;
      logic                                             ovf;
      logic                                             fault_q;
      logic [9:0]                                       dir_cnt;
      logic [1:0]                                       dir;
      logic [1:0]                                       ss;
      logic [1:0]                                       ok;
      logic [1:0]                                       d9;
      logic [1:0]                                       d10;
      logic                                             ready_led;
      logic                                             fault_led;
      logic [1:0]                                       axis_led;
      logic [1:0]                                       enc_led;
      logic [3:0]                                       prox_led;
   } smp_top_state_t;

   smp_top_state_t          s;
   smp_top_state_t          next_s;
   smp_pkg::smp_axis_out_t  ax1;
   smp_pkg::smp_axis_out_t  ax2;
   logic                    ext_fault;
   logic                    int_fault;
   logic                    axis_run;

   assign ext_fault = axis1_i.enc_short | axis2_i.enc_short;
   assign int_fault = internal_fault_i;
   // evaluation waits for the loaded configuration; any fault forces the safe condition
   assign axis_run  = s.run & ~ext_fault & ~int_fault;

   smp_axis u_axis1 (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .run_i      (axis_run),
      .shear_en_i (s.shear[0]),
      .delay_ms_i (s.dly1),
      .ms_tick_i  (s.ms_tick),
      .in_i       (axis1_i),
      .out_o      (ax1)
   );

   smp_axis u_axis2 (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .run_i      (axis_run),
      .shear_en_i (s.shear[1]),
      .delay_ms_i (s.dly2),
      .ms_tick_i  (s.ms_tick),
      .in_i       (axis2_i),
      .out_o      (ax2)
   );

   function automatic logic [31:0] smp_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [11:0] smp_clamp(input logic [11:0] v);
      return (v > smp_pkg::SMP_DLY_MAX_MS) ? smp_pkg::SMP_DLY_MAX_MS : v;
   endfunction

   function automatic logic smp_axis_led(input smp_pkg::smp_axis_out_t o,
                                         input logic enc_short,
                                         input logic [9:0] blink);
      logic slow;
      logic fast;
      logic brief;
      slow  = blink[smp_pkg::SMP_BLINK_SLOW];
      fast  = blink[smp_pkg::SMP_BLINK_FAST];
      brief = (blink[smp_pkg::SMP_BLINK_SLOW:smp_pkg::SMP_BLINK_FAST] == 3'h0);
      if (o.diag10 | enc_short) begin
         return brief;
      end else if (o.standstill) begin
         return 1'b1;
      end else if (!o.ovs_ok) begin
         return fast;
      end
      return slow;
   endfunction

   always_comb begin
      logic [31:0] wval;
      logic [31:0] sword;
      logic        pop;
      logic        fault_now;
      wval      = 32'h0;
      sword     = 32'h0;
      pop       = 1'b0;
      fault_now = 1'b0;
      next_s    = s;

      // millisecond time base for delays and blinking
      next_s.ms_tick = 1'b0;
      if (s.ms_cnt >= 32'(MS_CYCLES - 1)) begin
         next_s.ms_cnt  = 32'h0;
         next_s.ms_tick = 1'b1;
         next_s.blink   = s.blink + 10'h001;
      end else begin
         next_s.ms_cnt = s.ms_cnt + 32'h1;
      end

      // write channel: address and data taken independently, answered together
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         next_s.aw_full = 1'b1;
         next_s.aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         next_s.w_full = 1'b1;
         next_s.w_data = s_axi_wdata_i;
         next_s.w_strb = s_axi_wstrb_i;
      end
      if (s.bvalid && s_axi_bready_i) begin
         next_s.bvalid = 1'b0;
      end
      if (s.aw_full && s.w_full && !s.bvalid) begin
         next_s.aw_full = 1'b0;
         next_s.w_full  = 1'b0;
         next_s.bvalid  = 1'b1;
         next_s.bresp   = smp_pkg::SMP_RESP_OKAY;
         unique case (s.aw_addr)
            smp_pkg::SMP_ADDR_CTRL: begin
               wval = smp_merge({29'h0, s.shear, s.run}, s.w_data, s.w_strb);
               next_s.run   = wval[smp_pkg::SMP_CTRL_RUN];
               next_s.shear = {wval[smp_pkg::SMP_CTRL_SHEAR2], wval[smp_pkg::SMP_CTRL_SHEAR1]};
            end
            smp_pkg::SMP_ADDR_DLY1: begin
               wval = smp_merge({20'h0, s.dly1}, s.w_data, s.w_strb);
               next_s.dly1 = smp_clamp(wval[11:0]);
            end
            smp_pkg::SMP_ADDR_DLY2: begin
               wval = smp_merge({20'h0, s.dly2}, s.w_data, s.w_strb);
               next_s.dly2 = smp_clamp(wval[11:0]);
            end
            smp_pkg::SMP_ADDR_STATUS, smp_pkg::SMP_ADDR_ERR: ;
            default: next_s.bresp = smp_pkg::SMP_RESP_SLVERR;
         endcase
      end

      // status word
      sword[3:0] = {s.d10[0], s.d9[0], s.ok[0], s.ss[0]};
      sword[smp_pkg::SMP_ST_AXIS2 +: 4] = {s.d10[1], s.d9[1], s.ok[1], s.ss[1]};
      sword[smp_pkg::SMP_ST_EXT]   = ext_fault;
      sword[smp_pkg::SMP_ST_INT]   = int_fault;
      sword[smp_pkg::SMP_ST_DIRV]  = (s.dir_cnt == 10'h000);
      sword[smp_pkg::SMP_ST_READY] = s.ready_led;
      sword[smp_pkg::SMP_ST_CNT +: 4] = s.cnt;

      // read channel: one cycle to answer, reading the stack pops its top
      if (s.rvalid && s_axi_rready_i) begin
         next_s.rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && s_axi_arready_o) begin
         next_s.rvalid = 1'b1;
         next_s.rresp  = smp_pkg::SMP_RESP_OKAY;
         next_s.rdata  = 32'h0;
         unique case (s_axi_araddr_i)
            smp_pkg::SMP_ADDR_CTRL:   next_s.rdata = {29'h0, s.shear, s.run};
            smp_pkg::SMP_ADDR_DLY1:   next_s.rdata = {20'h0, s.dly1};
            smp_pkg::SMP_ADDR_DLY2:   next_s.rdata = {20'h0, s.dly2};
            smp_pkg::SMP_ADDR_STATUS: next_s.rdata = sword;
            smp_pkg::SMP_ADDR_ERR: begin
               next_s.rdata[smp_pkg::SMP_ERR_OVF] = s.ovf;
               if (s.cnt != 4'h0) begin
                  pop = 1'b1;
                  next_s.rdata[4:0] = s.stk[s.cnt[2:0] - 3'h1];
                  next_s.rdata[smp_pkg::SMP_ERR_VALID] = 1'b1;
               end
               next_s.ovf = 1'b0;
            end
            default: next_s.rresp = smp_pkg::SMP_RESP_SLVERR;
         endcase
      end

      // error stack: pop first, then push one pending entry, axis 1 ahead of axis 2
      if (pop) begin
         next_s.cnt = s.cnt - 4'h1;
      end
      if (s.pend != 2'b00) begin
         if (next_s.cnt < 4'(smp_pkg::SMP_STK_DEPTH)) begin
            next_s.stk[next_s.cnt[2:0]] = s.pend[0] ? {1'b0, ax1.code} : {1'b1, ax2.code};
            next_s.cnt = next_s.cnt + 4'h1;
         end else begin
            next_s.ovf = 1'b1; // full stack drops the newest entry and flags it
         end
         next_s.pend = s.pend[0] ? {s.pend[1], 1'b0} : 2'b00;
      end
      // a request arriving while another is served is kept: set wins
      next_s.pend = next_s.pend | {ax2.log_req, ax1.log_req};

      // direction is unreliable for a while after any fault
      fault_now     = ext_fault | int_fault;
      next_s.fault_q = fault_now;
      if (fault_now && !s.fault_q) begin
         next_s.dir_cnt = smp_pkg::SMP_DIR_HOLD_MS;
      end else if (s.ms_tick && s.dir_cnt != 10'h000) begin
         next_s.dir_cnt = s.dir_cnt - 10'h001;
      end
      next_s.dir = {axis2_i.direction, axis1_i.direction};

      // axis outputs
      next_s.ss  = {ax2.standstill, ax1.standstill};
      next_s.ok  = {ax2.ovs_ok, ax1.ovs_ok};
      next_s.d9  = {ax2.diag9, ax1.diag9};
      next_s.d10 = {ax2.diag10, ax1.diag10};

      // indicators
      next_s.ready_led = s.run & ~fault_now;
      if (int_fault) begin
         next_s.fault_led = s.blink[smp_pkg::SMP_BLINK_SLOW];
      end else begin
         next_s.fault_led = ext_fault;
      end
      next_s.enc_led[0] = axis1_i.enc_short ? s.blink[smp_pkg::SMP_BLINK_FAST]
                                            : axis1_i.enc_connected;
      next_s.enc_led[1] = axis2_i.enc_short ? s.blink[smp_pkg::SMP_BLINK_FAST]
                                            : axis2_i.enc_connected;
      next_s.axis_led[0] = smp_axis_led(ax1, axis1_i.enc_short, s.blink);
      next_s.axis_led[1] = smp_axis_led(ax2, axis2_i.enc_short, s.blink);
      next_s.prox_led = {axis2_i.prox_b, axis2_i.prox_a, axis1_i.prox_b, axis1_i.prox_a};
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         s      <= '0;
         s.dly1 <= smp_pkg::SMP_DLY_RST;
         s.dly2 <= smp_pkg::SMP_DLY_RST;
      end else begin
         s <= next_s;
      end
   end

   // bus handshakes
   assign s_axi_awready_o = ~s.aw_full & ~s.bvalid;
   assign s_axi_wready_o  = ~s.w_full & ~s.bvalid;
   assign s_axi_bvalid_o  = s.bvalid;
   assign s_axi_bresp_o   = s.bresp;
   assign s_axi_arready_o = ~s.rvalid;
   assign s_axi_rvalid_o  = s.rvalid;
   assign s_axi_rdata_o   = s.rdata;
   assign s_axi_rresp_o   = s.rresp;

   // outputs
   assign standstill_o             = s.ss;
   assign ovs_ok_o                 = s.ok;
   assign diag9_o                  = s.d9;
   assign diag10_o                 = s.d10;
   assign direction_o              = s.dir;
   assign direction_valid_o        = (s.dir_cnt == 10'h000);
   assign ready_led_o              = s.ready_led;
   assign fault_led_o              = s.fault_led;
   assign axis1_state_indicator_o  = s.axis_led[0];
   assign axis2_state_indicator_o  = s.axis_led[1];
   assign axis1_encoder_port_led_o = s.enc_led[0];
   assign axis2_encoder_port_led_o = s.enc_led[1];
   assign axis1_prox_input_a_led_o = s.prox_led[0];
   assign axis1_prox_input_b_led_o = s.prox_led[1];
   assign axis2_prox_input_a_led_o = s.prox_led[2];
   assign axis2_prox_input_b_led_o = s.prox_led[3];

endmodule
`default_nettype wire

// *** testbench/smp_sensors.sv ***
`timescale 1ns/1ns
`default_nettype none
module smp_sensors (
   input  wire logic [6:0]        set1_i,
   input  wire logic [6:0]        set2_i,
   output smp_pkg::smp_axis_in_t  axis1_o,
   output smp_pkg::smp_axis_in_t  axis2_o
);
   // with an encoder fitted the lone proximity switch sits on input a, input b stays unused
   function automatic smp_pkg::smp_axis_in_t mk(input logic [6:0] s);
      mk = {s[6:5], s[4] & s[2], s[4] & !s[2], s[3:0]};
   endfunction
   assign axis1_o = mk(set1_i);
   assign axis2_o = mk(set2_i);
endmodule
`default_nettype wire

// *** testbench/smp_monitor_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
module smp_monitor_checker (
   input wire logic                  clk_i,
   input wire logic                  rst_i,
   input wire smp_pkg::smp_axis_in_t axis1_i,
   input wire smp_pkg::smp_axis_in_t axis2_i,
   input wire logic                  internal_fault_i,
   input wire logic [1:0]            standstill_o,
   input wire logic [1:0]            ovs_ok_o,
   input wire logic [1:0]            diag9_o,
   input wire logic [1:0]            diag10_o,
   input wire logic                  ready_led_o,
   input wire logic                  fault_led_o
);
   logic [2:0] p1, p2;
   logic       r1, r2;
   wire logic [2:0] s1 = {axis1_i.track_a, axis1_i.track_b, axis1_i.prox_a | axis1_i.prox_b};
   wire logic [2:0] o1 = {standstill_o[0], diag9_o[0], diag10_o[0]};
   // judge a pattern only once it has held two edges while ready, so the output pipe has settled
   wire logic       k1 = ready_led_o & r1 & r2 & (p1 == p2);
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) {p1, p2, r1, r2} <= '0;
      else {p1, p2, r1, r2} <= {s1, p1, ready_led_o, r1};
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   property p_a; k1 && p2 == 3'b000 |-> o1 == 3'b100 && ovs_ok_o[0]; endproperty
   a_a: assert property (p_a) else $error("idle state");
   property p_b; k1 && p2 == 3'b001 |-> o1[1:0] == 2'b10; endproperty
   a_b: assert property (p_b) else $error("prox only state");
   property p_c; k1 && p2 inside {3'b010, 3'b100} |-> o1 == 3'b100 && ovs_ok_o[0]; endproperty
   a_c: assert property (p_c) else $error("one track state");
   property p_d; k1 && p2 inside {3'b011, 3'b101} |-> o1 == 3'b001; endproperty
   a_d: assert property (p_d) else $error("track diff state");
   property p_g; k1 && p2 == 3'b110 |-> o1 == 3'b010; endproperty
   a_g: assert property (p_g) else $error("no prox state");
   property p_h; k1 && p2 == 3'b111 |-> o1 == 3'b000; endproperty
   a_h: assert property (p_h) else $error("rotating state");
   property p_int; internal_fault_i [*3] |-> !ready_led_o && !standstill_o && !ovs_ok_o; endproperty
   a_int: assert property (p_int) else $error("internal fault");
   property p_ext; (axis2_i.enc_short && !internal_fault_i) [*3] |-> fault_led_o && !standstill_o; endproperty
   a_ext: assert property (p_ext) else $error("external fault");
endmodule
bind smp_monitor smp_monitor_checker i_smp_monitor_checker (.*);
`default_nettype wire

// *** testbench/testbench.sv ***
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic clk_i = 0, rst_i = 1, awv = 0, wv = 0, arv = 0, rdy = 0, flt = 0;
   logic [7:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd, r;
   logic [1:0] rr;
   logic [6:0] set1 = 0, set2 = 0;
   logic [3:0] e;
   smp_pkg::smp_axis_in_t ax1, ax2;
   wire logic awr, wrd, bv, arr, rv, rled, fled, dv, sled, eled, pled;
   wire logic [1:0] bresp, rresp, ss, ok, d9, d10;
   wire logic [31:0] rdata;
   int n_errors = 0, checks = 0, cyc = 0;
   always #5 clk_i = ~clk_i;
   smp_sensors i_smp_sensors (.set1_i(set1), .set2_i(set2), .axis1_o(ax1), .axis2_o(ax2));
   smp_monitor #(.MS_CYCLES(10)) i_smp_monitor (.clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awa),
      .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf),
      .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(rdy),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(rdy), .axis1_i(ax1), .axis2_i(ax2),
      .internal_fault_i(flt), .standstill_o(ss), .ovs_ok_o(ok), .diag9_o(d9), .diag10_o(d10),
      .direction_o(), .direction_valid_o(dv), .ready_led_o(rled), .fault_led_o(fled),
      .axis1_state_indicator_o(sled), .axis2_state_indicator_o(), .axis1_encoder_port_led_o(eled),
      .axis2_encoder_port_led_o(), .axis1_prox_input_a_led_o(pled), .axis1_prox_input_b_led_o(),
      .axis2_prox_input_a_led_o(), .axis2_prox_input_b_led_o());
   // {standstill, overspeed ok, bit 9, bit 10}, one nibble per {track a, track b, prox}
   function automatic logic [3:0] ex(input logic [2:0] c, input logic sh);
      ex = (sh && c == 3'b001) ? 4'h2 : 4'(32'h465c5cec >> {c, 2'b00});
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      if (w) {awa, wd, awv, wv, rdy} <= {a, d, 3'b111};
      else {ara, arv, rdy} <= {a, 2'b11};
      do begin
         @(posedge clk_i);
         if (awr) awv <= 0;
         if (wrd) wv <= 0;
         if (arr) arv <= 0;
         {rd, rr} = {rdata, w ? bresp : rresp};
      end while (!(w ? bv : rv));
      rdy <= 0;
   endtask
   task automatic summarize;
      $display("errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         summarize;
      end
   end
   initial begin
      r = $urandom(32'h88a3);
      repeat (10) @(posedge clk_i);
      rst_i <= 0;
      for (int s = 0; s < 2; s++) begin
         bus(1, smp_pkg::SMP_ADDR_CTRL, {30'h0, s[0], 1'b1});
         for (int c = 0; c < 8; c++) begin
            r = $urandom;
            {set1, set2} <= {c[2:0], 3'b010, r[0], r[3:1], 4'b0000};
            repeat (6) @(posedge clk_i);
            e = ex(c[2:0], s[0]);
            chk({ss[0], ok[0], d9[0], d10[0]}, e);
            chk({eled, pled}, {1'b1, c[0]});
            if (e[3]) chk(sled, 1);
            chk({ss[1], ok[1], d9[1], d10[1]}, ex(r[3:1], 1'b0));
         end
      end
      bus(0, smp_pkg::SMP_ADDR_ERR, 0);
      chk(rd[smp_pkg::SMP_ERR_VALID], 1);
      bus(0, 8'h40, 0);
      chk(rr, smp_pkg::SMP_RESP_SLVERR);
      bus(1, 8'h40, 0);
      chk(rr, smp_pkg::SMP_RESP_SLVERR);
      bus(1, smp_pkg::SMP_ADDR_DLY1, 2);
      set1 <= 7'b1111100;
      for (int i = 0; i < 50; i++) begin
         @(posedge clk_i);
         chk({rled, dv}, 2'b11);
         if (i == 22) chk(ok[0], 1);
      end
      chk(ok[0], 0);
      set2 <= 7'b0000110;
      repeat (4) @(posedge clk_i);
      chk({fled, ss, ok, dv}, 6'b100000);
      flt <= 1;
      repeat (4) @(posedge clk_i);
      chk({ss, ok, rled}, 5'b0);
      summarize;
   end
endmodule
`default_nettype wire
